//--- verif/scer_drv_model.sv
`timescale 1ns/1ns
`default_nettype none
module scer_drv_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] flags,
  output logic vld,
  output logic [7:0] status
);
  // flags stand one cycle with valid, then are inverted
  always_ff @(posedge clk) begin
    vld <= go;
    status <= go ? flags : ~flags;
  end
endmodule
`default_nettype wire

//--- verif/step_config_and_event_routing_tb.sv
`timescale 1ns/1ns
`default_nettype none
module step_config_and_event_routing_tb;
  import scer_pkg::*;
  logic clk, rst, wr, rd_s, go, vld, interrupt_output;
  logic [7:0] addr, flags, dstat, drv_st, dmask;
  logic [31:0] wdata, rdata, ev;
  logic [8:0] usteps;
  logic [11:0] fsrev;
  int failures = 0;
  int n_tests = 0;
  scer_top scer_top_i (.CLK_SYS(clk), .RST(rst), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd_s), .RDATA(rdata), .EVENT_SET(ev),
    .DRV_STATUS_VLD(vld), .DRV_STATUS(drv_st), .DGRAM_STATUS(dstat),
    .INTERRUPT_OUTPUT(interrupt_output), .MICROSTEPS_PER_FS(usteps),
    .FULLSTEPS_PER_REVOLUTION(fsrev), .DRIVER_STATUS_MASK(dmask));
  scer_drv_model scer_drv_model_i (.clk(clk), .go(go), .flags(flags),
    .vld(vld), .status(drv_st));
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 chk("rdata", e, rdata);
  endtask
  task pulse(input logic [31:0] v, input logic [7:0] e);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= 32'h00000000;
    #1 chk("dgram", 32'(e), 32'(dstat));
  endtask
  task drv(input logic [7:0] f, input logic e);
    @(posedge clk);
    go <= 1'b1;
    flags <= f;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    #1 chk("interrupt_output", 32'(e), 32'(interrupt_output));
  endtask
  task t_reset;
    #1 chk("usteps", 32'h100, 32'(usteps));
    rd_reg(SCER_ADDR_STEP, 32'h00FB0C80);
    rd_reg(SCER_ADDR_SPISEL, 32'h82029805);
    rd_reg(SCER_ADDR_PROT, 32'h00000000);
    rd_reg(SCER_ADDR_INTERRUPT_OUTPUT, 32'h00000000);
    wr_reg(8'h10, 32'hFFFFFFFF);
    wr_reg(SCER_ADDR_EVENTS, 32'hFFFFFFFF);
    rd_reg(8'h10, 32'h00000000);
    rd_reg(SCER_ADDR_EVENTS, 32'h00000000);
  endtask
  task t_mres;
    int m;
    for (int c = 0; c < 10; c++) begin
      m = (c > 8) ? 8 : c;
      wr_reg(SCER_ADDR_STEP, {16'hFF5A, 12'(100 + c), 4'(c)});
      #1 chk("usteps", 32'(9'h100 >> m), 32'(usteps));
      chk("fsrev", 32'(100 + c), 32'(fsrev));
      chk("dmask", 32'h5A, 32'(dmask));
      rd_reg(SCER_ADDR_STEP, {16'h005A, 12'(100 + c), 4'(m)});
    end
  endtask
  task t_events;
    wr_reg(SCER_ADDR_SPISEL, 32'h4000000E);
    wr_reg(SCER_ADDR_PROT, 32'h00000004);
    wr_reg(SCER_ADDR_INTERRUPT_OUTPUT, 32'h00000008);
    pulse(32'h4000000F, 8'h0F);
    chk("interrupt_output", 32'h1, 32'(interrupt_output));
    rd_reg(SCER_ADDR_EVENTS, 32'h4000000F);
    chk("interrupt_output", 32'h0, 32'(interrupt_output));
    chk("dgram", 32'h02, 32'(dstat));
    rd_reg(SCER_ADDR_EVENTS, 32'h00000004);
    wr_reg(SCER_ADDR_SPISEL, 32'h000001FF);
    pulse(32'h00000100, 8'h04);
    pulse(32'h00000080, 8'h84);
    rd_reg(SCER_ADDR_EVENTS, 32'h00000184);
    wr_reg(SCER_ADDR_SPISEL, 32'h00000000);
    pulse(32'h00000010, 8'h00);
  endtask
  task t_drv;
    wr_reg(SCER_ADDR_PROT, 32'h00000000);
    rd_reg(SCER_ADDR_EVENTS, 32'h00000014);
    wr_reg(SCER_ADDR_STEP, 32'h00010C80);
    wr_reg(SCER_ADDR_INTERRUPT_OUTPUT, 32'h40000000);
    drv(8'hFE, 1'b0);
    drv(8'h01, 1'b1);
    rd_reg(SCER_ADDR_EVENTS, 32'h40000000);
  endtask
  task end_of_test;
    if (failures == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd_s = 1'b0;
    go = 1'b0;
    addr = 8'h00;
    wdata = 32'h00000000;
    ev = 32'h00000000;
    flags = 8'h00;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_mres;
    t_events;
    t_drv;
    end_of_test;
  end
endmodule
`default_nettype wire

//--- verilog/scer_mstep.sv
`timescale 1ns/1ns
`default_nettype none
module scer_mstep
  import scer_pkg::*;
(
  input wire logic [3:0] code,
  output logic [8:0] usteps
);
  // [R02] finest is 256
  // [R01] each code halves, 8 is full step
  assign usteps = (code <= SCER_MRES_MAX) ? (SCER_USTEP_FINEST >> code)
                                          : 9'h001;
endmodule
`default_nettype wire

//--- verilog/scer_pkg.sv
// Contract
// [R01] codes 5..8 give 8,4,2,1 microsteps
// [R02] code 0 gives 256, each code halves
// [R03] fullsteps per revolution in bits 15:4
// [R04] masked driver status flag raises event 30
// [R05] first eight selected events form datagram status
// [R06] protected events survive event register read
// [R07] interrupt is OR of selected events
`default_nettype none
package scer_pkg;
  localparam logic [7:0] SCER_ADDR_STEP = 8'h0A;
  localparam logic [7:0] SCER_ADDR_SPISEL = 8'h0B;
  localparam logic [7:0] SCER_ADDR_PROT = 8'h0C;
  localparam logic [7:0] SCER_ADDR_INTERRUPT_OUTPUT = 8'h0D;
  localparam logic [7:0] SCER_ADDR_EVENTS = 8'h0E;

  localparam int SCER_MRES_LSB = 0;
  localparam int SCER_FSREV_LSB = 4;
  localparam int SCER_DMASK_LSB = 16;
  localparam int SCER_DRV_EVENT_BIT = 30;

  localparam logic [3:0] SCER_MRES_RST = 4'h0;
  localparam logic [3:0] SCER_MRES_MAX = 4'h8;
  localparam logic [11:0] SCER_FSREV_RST = 12'h0C8;
  localparam logic [7:0] SCER_DMASK_RST = 8'hFB;
  localparam logic [31:0] SCER_SPISEL_RST = 32'h82029805;
  localparam logic [31:0] SCER_PROT_RST = 32'h00000000;
  localparam logic [31:0] SCER_INTERRUPT_OUTPUT_RST = 32'h00000000;
  localparam logic [31:0] SCER_EVENTS_RST = 32'h00000000;
  localparam logic [8:0] SCER_USTEP_FINEST = 9'h100;

  typedef struct packed {
    logic [7:0] drv_mask;
    logic [11:0] fs_rev;
    logic [3:0] mres;
  } scer_step_cfg_t;
endpackage
`default_nettype wire

//--- verilog/scer_top.sv
`timescale 1ns/1ns
`default_nettype none
module scer_top
  import scer_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic [31:0] EVENT_SET,
  input wire logic DRV_STATUS_VLD,
  input wire logic [7:0] DRV_STATUS,
  output logic [7:0] DGRAM_STATUS,
  output logic INTERRUPT_OUTPUT,
  output logic [8:0] MICROSTEPS_PER_FS,
  output logic [11:0] FULLSTEPS_PER_REVOLUTION,
  output logic [7:0] DRIVER_STATUS_MASK
);
  if (ADDR_W < 4 || ADDR_W > 8) begin : g_chk
    $error("scer_top: ADDR_W must be 4 to 8");
  end

  // gathers the first eight selected event bits, lowest position first
  function automatic logic [7:0] pick8(input logic [31:0] ev,
                                       input logic [31:0] sel);
    logic [7:0] r;
    logic [3:0] n;
    r = 8'h00;
    n = 4'h0;
    for (int i = 0; i < 32; i++) begin
      if (sel[i] && n < 4'h8) begin
        r[n[2:0]] = ev[i];
        n = n + 4'h1;
      end
    end
    return r;
  endfunction

  scer_step_cfg_t step_q, step_d;
  logic [31:0] spisel_q, spisel_d;
  logic [31:0] prot_q, prot_d;
  logic [31:0] interrupt_output_q, interrupt_output_d;
  logic [31:0] events_q, events_d;
  logic [31:0] rdata_q, rdata_d;
  logic [7:0] dgram_q;

  wire [7:0] addr8 = 8'(ADDR);
  wire wr_step = WR && addr8 == SCER_ADDR_STEP;
  wire wr_spisel = WR && addr8 == SCER_ADDR_SPISEL;
  wire wr_prot = WR && addr8 == SCER_ADDR_PROT;
  wire wr_interrupt_output = WR && addr8 == SCER_ADDR_INTERRUPT_OUTPUT;
  wire rd_events = RD && addr8 == SCER_ADDR_EVENTS;
  wire [3:0] wr_mres = WDATA[SCER_MRES_LSB +: 4];
  wire [31:0] step_word = {8'h00, step_q.drv_mask, step_q.fs_rev,
                           step_q.mres};

  // [R04] driver status flags through mask
  wire drv_hit = DRV_STATUS_VLD && |(DRV_STATUS & step_q.drv_mask);
  wire [31:0] new_events = EVENT_SET |
                           (32'(drv_hit) << SCER_DRV_EVENT_BIT);

  // [R03] fields of the settings register
  always_comb begin
    step_d = step_q;
    if (wr_step) begin
      step_d.mres = (wr_mres > SCER_MRES_MAX) ? SCER_MRES_MAX : wr_mres;
      step_d.fs_rev = WDATA[SCER_FSREV_LSB +: 12];
      step_d.drv_mask = WDATA[SCER_DMASK_LSB +: 8];
    end
  end

  assign spisel_d = wr_spisel ? WDATA : spisel_q;
  assign prot_d = wr_prot ? WDATA : prot_q;
  assign interrupt_output_d = wr_interrupt_output ? WDATA : interrupt_output_q;

  // [R06] read clears unprotected events, new sets win
  assign events_d = (rd_events ? (events_q & prot_q) : events_q) |
                    new_events;

  always_comb begin
    rdata_d = 32'h00000000;
    if (RD) begin
      unique case (addr8)
        SCER_ADDR_STEP: rdata_d = step_word;
        SCER_ADDR_SPISEL: rdata_d = spisel_q;
        SCER_ADDR_PROT: rdata_d = prot_q;
        SCER_ADDR_INTERRUPT_OUTPUT: rdata_d = interrupt_output_q;
        SCER_ADDR_EVENTS: rdata_d = events_q;
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      step_q <= '{SCER_DMASK_RST, SCER_FSREV_RST, SCER_MRES_RST};
      spisel_q <= SCER_SPISEL_RST;
      prot_q <= SCER_PROT_RST;
      interrupt_output_q <= SCER_INTERRUPT_OUTPUT_RST;
      events_q <= SCER_EVENTS_RST;
      rdata_q <= 32'h00000000;
      dgram_q <= 8'h00;
    end else begin
      step_q <= step_d;
      spisel_q <= spisel_d;
      prot_q <= prot_d;
      interrupt_output_q <= interrupt_output_d;
      events_q <= events_d;
      rdata_q <= rdata_d;
      // [R05] datagram status from selected events
      dgram_q <= pick8(events_d, spisel_d);
    end
  end

  scer_mstep u_mstep (
    .code(step_q.mres),
    .usteps(MICROSTEPS_PER_FS)
  );

  assign RDATA = rdata_q;
  assign DGRAM_STATUS = dgram_q;
  // [R07] OR of selected events
  assign INTERRUPT_OUTPUT = |(events_q & interrupt_output_q);
  assign FULLSTEPS_PER_REVOLUTION = step_q.fs_rev;
  assign DRIVER_STATUS_MASK = step_q.drv_mask;

  sequence s_step_write;
    wr_step && WDATA[SCER_MRES_LSB +: 4] == 4'h5;
  endsequence

  property p_mres_eight;
    @(posedge CLK_SYS) disable iff (RST)
      s_step_write |=> MICROSTEPS_PER_FS == 9'h008;
  endproperty
  a_mres_eight: assert property (p_mres_eight) // [R01]
    else $error("code 5 not decoded as 8 microsteps");

  property p_mres_full;
    @(posedge CLK_SYS) disable iff (RST)
      step_q.mres == 4'h8 |-> MICROSTEPS_PER_FS == 9'h001;
  endproperty
  a_mres_full: assert property (p_mres_full) // [R01]
    else $error("code 8 not decoded as full step");

  property p_mres_finest;
    @(posedge CLK_SYS) disable iff (RST)
      step_q.mres == 4'h0 |-> MICROSTEPS_PER_FS == 9'h100;
  endproperty
  a_mres_finest: assert property (p_mres_finest) // [R02]
    else $error("code 0 not decoded as 256 microsteps");

  property p_fsrev_write;
    @(posedge CLK_SYS) disable iff (RST)
      wr_step |=> FULLSTEPS_PER_REVOLUTION ==
                  $past(WDATA[SCER_FSREV_LSB +: 12]) &&
                  RDATA == 32'h00000000;
  endproperty
  a_fsrev_write: assert property (p_fsrev_write) // [R03]
    else $error("fullsteps field not written from bits 15:4");

  property p_drv_event;
    @(posedge CLK_SYS) disable iff (RST)
      DRV_STATUS_VLD && |(DRV_STATUS & DRIVER_STATUS_MASK)
        |=> events_q[30];
  endproperty
  a_drv_event: assert property (p_drv_event) // [R04]
    else $error("masked driver flag did not raise event 30");

  property p_dgram;
    @(posedge CLK_SYS) disable iff (RST)
      1'b1 |=> DGRAM_STATUS == pick8(events_q, spisel_q);
  endproperty
  a_dgram: assert property (p_dgram) // [R05]
    else $error("datagram status does not follow selection");

  sequence s_evt_read;
    rd_events ##1 1'b1;
  endsequence

  property p_protect;
    @(posedge CLK_SYS) disable iff (RST)
      s_evt_read |-> events_q == (($past(events_q) & $past(prot_q)) |
                                  $past(new_events)) &&
                     RDATA == $past(events_q);
  endproperty
  a_protect: assert property (p_protect) // [R06]
    else $error("event read did not keep protected bits only");

  property p_interrupt_output;
    @(posedge CLK_SYS) disable iff (RST)
      (events_q & interrupt_output_q) != 32'h00000000 |-> INTERRUPT_OUTPUT ##1
      ((events_q & interrupt_output_q) == 32'h00000000) == !INTERRUPT_OUTPUT;
  endproperty
  a_interrupt_output: assert property (p_interrupt_output) // [R07]
    else $error("interrupt does not follow selected events");

  property p_mres_clamp;
    @(posedge CLK_SYS) disable iff (RST)
      wr_step && WDATA[SCER_MRES_LSB +: 4] > SCER_MRES_MAX
        |=> MICROSTEPS_PER_FS == 9'h001 && step_q.mres == SCER_MRES_MAX;
  endproperty
  a_mres_clamp: assert property (p_mres_clamp) // [R01]
    else $error("microstep code above 8 not held at full step");

  property p_drv_masked;
    @(posedge CLK_SYS) disable iff (RST)
      !events_q[SCER_DRV_EVENT_BIT] && !EVENT_SET[SCER_DRV_EVENT_BIT] &&
      !(DRV_STATUS_VLD && (DRV_STATUS & DRIVER_STATUS_MASK) != 8'h00)
        |=> !events_q[SCER_DRV_EVENT_BIT];
  endproperty
  a_drv_masked: assert property (p_drv_masked) // [R04]
    else $error("event 30 raised without a masked driver flag");

  property p_dgram_none;
    @(posedge CLK_SYS) disable iff (RST)
      spisel_q == 32'h00000000 && !wr_spisel |=> DGRAM_STATUS == 8'h00;
  endproperty
  a_dgram_none: assert property (p_dgram_none) // [R05]
    else $error("datagram status set with no event selected");

  property p_evt_sticky;
    @(posedge CLK_SYS) disable iff (RST)
      !rd_events |=> (events_q & $past(events_q)) == $past(events_q);
  endproperty
  a_evt_sticky: assert property (p_evt_sticky) // [R06]
    else $error("event bit cleared without a read");

  property p_interrupt_output_raise;
    @(posedge CLK_SYS) disable iff (RST)
      (EVENT_SET & interrupt_output_q) != 32'h00000000 && !wr_interrupt_output |=> INTERRUPT_OUTPUT;
  endproperty
  a_interrupt_output_raise: assert property (p_interrupt_output_raise) // [R07]
    else $error("selected event did not raise the interrupt");
endmodule
`default_nettype wire
